// *** touch_monitor_defs.vh ***
`ifndef TOUCH_MONITOR_DEFS_VH
`define TOUCH_MONITOR_DEFS_VH

// Register offsets
`define OFF_TIMING 6'h05
`define OFF_TEMP_UP 6'h06
`define OFF_TEMP_LO 6'h07
`define OFF_FIRST_AUX_INPUT_UP 6'h08
`define OFF_FIRST_AUX_INPUT_LO 6'h09
`define OFF_SECOND_AUX_INPUT_UP 6'h0a
`define OFF_SECOND_AUX_INPUT_LO 6'h0b

// Field positions
`define POS_PD 6
`define POS_PRE_HI 5
`define POS_PRE_LO 3
`define POS_SNS_HI 2
`define POS_SNS_LO 0
`define POS_EN 12

// Reset values
`define RST_UPPER 12'hfff
`define RST_LOWER 12'h000

// Channel codes on the conversion result port
`define CH_TEMP_A 2'h0
`define CH_TEMP_B 2'h1
`define CH_FIRST_AUX_INPUT 2'h2
`define CH_SECOND_AUX_INPUT 2'h3

// Timing
`define CLK_PERIOD_NS 10
`define PRE0_NS 20000
`define PRE1_NS 84000
`define PRE2_NS 276000
`define PRE3_NS 340000
`define PRE4_NS 1044000
`define PRE5_NS 1108000
`define PRE7_NS 1364000
`define SNS0_NS 32000
`define SNS1_NS 96000
`define SNS2_NS 544000
`define SNS3_NS 608000
`define SNS4_NS 2080000
`define SNS5_NS 2144000
`define SNS6_NS 2592000
`define SNS7_NS 2656000

`endif

// *** touch_threshold_monitor.v ***
`timescale 1ns/1ps
`default_nettype none
`include "touch_monitor_defs.vh"

module touch_threshold_monitor
#(
  parameter PRE0_CYC = `PRE0_NS / `CLK_PERIOD_NS,
  parameter PRE1_CYC = `PRE1_NS / `CLK_PERIOD_NS,
  parameter PRE2_CYC = `PRE2_NS / `CLK_PERIOD_NS,
  parameter PRE3_CYC = `PRE3_NS / `CLK_PERIOD_NS,
  parameter PRE4_CYC = `PRE4_NS / `CLK_PERIOD_NS,
  parameter PRE5_CYC = `PRE5_NS / `CLK_PERIOD_NS,
  parameter PRE7_CYC = `PRE7_NS / `CLK_PERIOD_NS,
  parameter SNS0_CYC = `SNS0_NS / `CLK_PERIOD_NS,
  parameter SNS1_CYC = `SNS1_NS / `CLK_PERIOD_NS,
  parameter SNS2_CYC = `SNS2_NS / `CLK_PERIOD_NS,
  parameter SNS3_CYC = `SNS3_NS / `CLK_PERIOD_NS,
  parameter SNS4_CYC = `SNS4_NS / `CLK_PERIOD_NS,
  parameter SNS5_CYC = `SNS5_NS / `CLK_PERIOD_NS,
  parameter SNS6_CYC = `SNS6_NS / `CLK_PERIOD_NS,
  parameter SNS7_CYC = `SNS7_NS / `CLK_PERIOD_NS
)
(
  // Clock, reset, enable
  input wire mclk,
  input wire rst_b,
  input wire clkEn,
  // Register port from the serial interface
  input wire [5:0] regAddr,
  input wire regWrEn,
  input wire [15:0] regWrData,
  input wire regRdEn,
  output reg [15:0] regRdData,
  // Measurement configuration bits held elsewhere
  input wire autoScan,
  input wire autoTempChannelSelect,
  input wire scanModeTempSelect,
  input wire limitInterruptPinRoute,
  // Conversion results
  input wire convValid,
  input wire [1:0] convChannel,
  input wire [11:0] convCode,
  // Touch panel sensing
  input wire penSense,
  output reg prechargeActive,
  output reg senseActive,
  output reg touchDetected,
  // Limit status
  output reg [5:0] limitFlags,
  output reg tempUpperLimitFlag,
  output reg limitInterrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  // Reserved precharge code and the one-hot states of the touch sequence
  localparam [2:0] PRE_RESERVED = 3'h6;
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_PRE = 4'h2;
  localparam [3:0] S_SNS = 4'h4;
  localparam [3:0] S_SMP = 4'h8;

  // Configuration fields, comparator storage and sequence counter
  reg touchDetectPowerDown_q;
  reg [2:0] prechargeTimeSelect_q;
  reg [2:0] senseTimeSelect_q;
  reg [5:0] checkEnable_q;
  reg [11:0] limitValue_q [0:5];
  reg [3:0] state_q;
  reg [18:0] count_q;
  // One loop index per process, so no variable is driven from two places
  integer iWr;
  integer iRd;
  integer iFlg;

  // Index 0..5: temp upper, temp lower, first_aux_input upper, first_aux_input lower, second_aux_input upper, second_aux_input lower
  // Reset waits for the clock enable as well, so a frozen block keeps every field
  always @(posedge mclk)
  begin
    if (!rst_b && clkEn)
    begin
      touchDetectPowerDown_q <= 1'b0;
      prechargeTimeSelect_q <= 3'h0;
      senseTimeSelect_q <= 3'h0;
      checkEnable_q <= 6'h00;
      limitValue_q[0] <= `RST_UPPER;
      limitValue_q[1] <= `RST_LOWER;
      limitValue_q[2] <= `RST_UPPER;
      limitValue_q[3] <= `RST_LOWER;
      limitValue_q[4] <= `RST_UPPER;
      limitValue_q[5] <= `RST_LOWER;
    end
    else if (clkEn && regWrEn)
    begin
      if (regAddr == `OFF_TIMING)
      begin
        touchDetectPowerDown_q <= regWrData[`POS_PD];
        prechargeTimeSelect_q <= regWrData[`POS_PRE_HI:`POS_PRE_LO];
        senseTimeSelect_q <= regWrData[`POS_SNS_HI:`POS_SNS_LO];
      end
      for (iWr = 0; iWr < 6; iWr = iWr + 1)
      begin
        if (regAddr == `OFF_TEMP_UP + iWr[5:0])
        begin
          checkEnable_q[iWr] <= regWrData[`POS_EN];
          limitValue_q[iWr] <= regWrData[11:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read path; unmapped offsets and reserved bits read zero

  reg [15:0] rdMux;

  always @*
  begin
    rdMux = 16'h0000;
    if (regAddr == `OFF_TIMING)
      rdMux = {9'h000, touchDetectPowerDown_q, prechargeTimeSelect_q, senseTimeSelect_q};
    for (iRd = 0; iRd < 6; iRd = iRd + 1)
    begin
      if (regAddr == `OFF_TEMP_UP + iRd[5:0])
        rdMux = {3'h0, checkEnable_q[iRd], limitValue_q[iRd]};
    end
  end

  // Read data is held until the next read so the serial shifter can take it late
  always @(posedge mclk)
  begin
    if (!rst_b && clkEn)
      regRdData <= 16'h0000;
    else if (clkEn && regRdEn)
      regRdData <= rdMux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Precharge and sense time lookup

  // Wide enough for any cycle count a parameter may carry
  reg [31:0] preCycles;
  reg [31:0] snsCycles;

  // Reserved precharge code falls back to the longest setting, the safe side
  always @*
  begin
    case (prechargeTimeSelect_q)
      3'h0: preCycles = PRE0_CYC;
      3'h1: preCycles = PRE1_CYC;
      3'h2: preCycles = PRE2_CYC;
      3'h3: preCycles = PRE3_CYC;
      3'h4: preCycles = PRE4_CYC;
      3'h5: preCycles = PRE5_CYC;
      PRE_RESERVED: preCycles = PRE7_CYC;
      default: preCycles = PRE7_CYC;
    endcase
  end

  // Every sense code is defined, so the default only stands for 3'h7
  always @*
  begin
    case (senseTimeSelect_q)
      3'h0: snsCycles = SNS0_CYC;
      3'h1: snsCycles = SNS1_CYC;
      3'h2: snsCycles = SNS2_CYC;
      3'h3: snsCycles = SNS3_CYC;
      3'h4: snsCycles = SNS4_CYC;
      3'h5: snsCycles = SNS5_CYC;
      3'h6: snsCycles = SNS6_CYC;
      default: snsCycles = SNS7_CYC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pen touch detection sequence: precharge, sense wait, sample, repeat

  // Counts start at zero, so a phase of N cycles ends when the count reaches N-1
  wire countDone;
  assign countDone = (state_q == S_PRE) ? (count_q >= preCycles[18:0] - 19'h00001)
                                        : (count_q >= snsCycles[18:0] - 19'h00001);

  // Reset and power-down both park the sequence in idle with no touch reported
  always @(posedge mclk)
  begin
    if (!rst_b && clkEn)
    begin
      state_q <= S_IDLE;
      count_q <= 19'h00000;
      touchDetected <= 1'b0;
    end
    else if (clkEn)
    begin
      if (touchDetectPowerDown_q)
      begin
        state_q <= S_IDLE;
        count_q <= 19'h00000;
        touchDetected <= 1'b0;
      end
      else
      begin
        case (state_q)
          S_IDLE:
          begin
            state_q <= S_PRE;
            count_q <= 19'h00000;
          end
          S_PRE:
          begin
            if (countDone)
            begin
              state_q <= S_SNS;
              count_q <= 19'h00000;
            end
            else
              count_q <= count_q + 19'h00001;
          end
          S_SNS:
          begin
            if (countDone)
              state_q <= S_SMP;
            else
              count_q <= count_q + 19'h00001;
          end
          S_SMP:
          begin
            touchDetected <= penSense;
            state_q <= S_PRE;
            count_q <= 19'h00000;
          end
          default:
          begin
            state_q <= S_IDLE;
            count_q <= 19'h00000;
          end
        endcase
      end
    end
  end

  // Phase outputs come straight from the one-hot state flops
  always @*
  begin
    prechargeActive = state_q[1];
    senseActive = state_q[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparators

  // Temperature result counts only for the channel in use in the current mode
  wire measuredTempB;
  wire tempHit;
  wire aux1Hit;
  wire aux2Hit;
  reg [5:0] hitMask;
  reg [5:0] cmpResult;

  // A result of the idle temperature channel leaves the temperature flags alone
  assign measuredTempB = autoScan ? autoTempChannelSelect : scanModeTempSelect;
  assign tempHit = convValid && (convChannel == (measuredTempB ? `CH_TEMP_B : `CH_TEMP_A));
  assign aux1Hit = convValid && (convChannel == `CH_FIRST_AUX_INPUT);
  assign aux2Hit = convValid && (convChannel == `CH_SECOND_AUX_INPUT);

  always @*
  begin
    // Both checks of a channel look at the same result
    hitMask = {aux2Hit, aux2Hit, aux1Hit, aux1Hit, tempHit, tempHit};
    cmpResult[0] = convCode >= limitValue_q[0];
    cmpResult[1] = convCode <= limitValue_q[1];
    cmpResult[2] = convCode >= limitValue_q[2];
    cmpResult[3] = convCode <= limitValue_q[3];
    cmpResult[4] = convCode >= limitValue_q[4];
    cmpResult[5] = convCode <= limitValue_q[5];
  end

  // Flags keep the latest result of each channel; a disabled check reads zero in limitFlags but not in tempUpperLimitFlag
  always @(posedge mclk)
  begin
    if (!rst_b && clkEn)
    begin
      limitFlags <= 6'h00;
      tempUpperLimitFlag <= 1'b0;
      limitInterrupt <= 1'b0;
    end
    else if (clkEn)
    begin
      for (iFlg = 0; iFlg < 6; iFlg = iFlg + 1)
      begin
        if (!checkEnable_q[iFlg])
          limitFlags[iFlg] <= 1'b0;
        else if (hitMask[iFlg])
          limitFlags[iFlg] <= cmpResult[iFlg];
      end
      if (tempHit)
        tempUpperLimitFlag <= cmpResult[0];
      // Masking closes the one-cycle gap before a flag of a cleared enable drops
      limitInterrupt <= limitInterruptPinRoute && |(limitFlags & checkEnable_q);
    end
  end

endmodule
`default_nettype wire

// *** touch_monitor_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module touch_monitor_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [5:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regRdData,
  // Conversions and status
  input wire logic convValid,
  input wire logic [1:0] convChannel,
  input wire logic limitInterruptPinRoute,
  input wire logic [5:0] limitFlags,
  input wire logic tempUpperLimitFlag,
  input wire logic limitInterrupt,
  // Touch phases
  input wire logic prechargeActive,
  input wire logic senseActive
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////
  // Interrupt is a level, one cycle behind the flags
  a_int_route: assert property (limitInterrupt |-> $past(limitInterruptPinRoute) && |$past(limitFlags))
    else $error("limit interrupt without routed flag");
  // A flag whose enable was just cleared stands one more cycle but is masked
  a_int_raise: assert property ($past(limitInterruptPinRoute) && |$past(limitFlags) && !$past(regWrEn, 2)
    |-> limitInterrupt) else $error("routed flag gave no interrupt");
  a_phase_excl: assert property (!(prechargeActive && senseActive))
    else $error("precharge and sense overlap");
  a_sense_after: assert property ($rose(senseActive) |-> $past(prechargeActive))
    else $error("sense began without precharge");
  a_temp_hold: assert property (!$past(convValid) |-> $stable(tempUpperLimitFlag))
    else $error("temp flag moved alone");
  a_flag_hold: assert property (!$past(convValid) && !$past(regWrEn, 2) |-> $stable(limitFlags))
    else $error("limit flags moved alone");
  a_cfg_reserved: assert property ($past(regRdEn) && $past(regAddr) == 6'h05 |-> regRdData[15:7] == 9'h000)
    else $error("config reserved bits set");
  a_temp_src: assert property ($rose(tempUpperLimitFlag) |-> $past(convValid) && !$past(convChannel[1]))
    else $error("temp flag without temp result");
  a_first_aux_input_src: assert property ($rose(limitFlags[2]) || $rose(limitFlags[3]) |-> $past(convChannel) == 2'h2)
    else $error("first_aux_input flag from other channel");
  a_second_aux_input_src: assert property ($rose(limitFlags[4]) || $rose(limitFlags[5]) |-> $past(convChannel) == 2'h3)
    else $error("second_aux_input flag from other channel");
endmodule
bind touch_threshold_monitor touch_monitor_asserts chk (.mclk, .rst_b, .regAddr, .regWrEn, .regRdEn, .regRdData,
  .convValid, .convChannel, .limitInterruptPinRoute, .limitFlags, .tempUpperLimitFlag, .limitInterrupt,
  .prechargeActive, .senseActive);
`default_nettype wire

// *** host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [5:0] regAddr,
  output logic regWrEn,
  output logic [15:0] regWrData,
  output logic regRdEn
);
  // Bus idle at time zero
  initial
  begin
    regAddr = 6'h00;
    regWrEn = 1'b0;
    regWrData = 16'h0000;
    regRdEn = 1'b0;
  end
  ////////////////////
  // One strobe cycle; lines then show the inverse so stale data cannot pass
  task automatic access(input logic w, input logic [5:0] a, input logic [15:0] d);
    logic [15:0] v;
    begin
      v = d;
      @(negedge mclk);
      regAddr = a;
      regWrData = v;
      regWrEn = w;
      regRdEn = !w;
      @(negedge mclk);
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = ~a;
      regWrData = ~v;
    end
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int PC[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
  localparam int SC[8] = '{5, 7, 9, 11, 13, 15, 17, 19};
  logic mclk = 1'b0, rst_b = 1'b0, autoScan = 1'b0, aSel = 1'b0, sSel = 1'b0, route = 1'b0, penSense = 1'b0;
  logic convValid = 1'b0, rdLate = 1'b0, cvLate = 1'b0, cvLate2 = 1'b0, tup = 1'b0, clkEn = 1'b1;
  logic [1:0] convChannel = 2'h0;
  logic [11:0] convCode = 12'h000;
  logic [11:0] up[3] = '{12'hfff, 12'hfff, 12'hfff}, lo[3] = '{12'h000, 12'h000, 12'h000};
  logic [5:0] en = 6'h00, flg = 6'h00;
  logic [15:0] rdQ[$];
  logic [6:0] flQ[$];
  logic intQ[$];
  int num_errors = 0, checks = 0, seed = 84, preRun = 0, senRun = 0, preLen = 0, senLen = 0;
  wire [5:0] regAddr, limitFlags;
  wire [15:0] regWrData, regRdData;
  wire regWrEn, regRdEn, prechargeActive, senseActive, touchDetected, tempUpperLimitFlag, limitInterrupt;
  // Short phase counts keep the run brief
  touch_threshold_monitor #(.PRE0_CYC(PC[0]), .PRE1_CYC(PC[1]), .PRE2_CYC(PC[2]), .PRE3_CYC(PC[3]),
    .PRE4_CYC(PC[4]), .PRE5_CYC(PC[5]), .PRE7_CYC(PC[7]), .SNS0_CYC(SC[0]), .SNS1_CYC(SC[1]),
    .SNS2_CYC(SC[2]), .SNS3_CYC(SC[3]), .SNS4_CYC(SC[4]), .SNS5_CYC(SC[5]), .SNS6_CYC(SC[6]), .SNS7_CYC(SC[7]))
  uut (.mclk, .rst_b, .clkEn, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .autoScan,
    .autoTempChannelSelect(aSel), .scanModeTempSelect(sSel), .limitInterruptPinRoute(route), .convValid,
    .convChannel, .convCode, .penSense, .prechargeActive, .senseActive, .touchDetected, .limitFlags,
    .tempUpperLimitFlag, .limitInterrupt);
  host_model host (.mclk, .regAddr, .regWrEn, .regWrData, .regRdEn);
  always #5 mclk = ~mclk;
  ////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
      checks++;
      if (seen !== exp)
        num_errors++;
      if (seen !== exp)
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    begin
      if (num_errors == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Reads note their result before the strobe goes out
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    begin
      rdQ.push_back(e);
      host.access(1'b0, a, 16'h0000);
    end
  endtask
  task automatic setlim(input int p, input logic ue, input logic [11:0] u, input logic le, input logic [11:0] l);
    begin
      host.access(1'b1, 6'(6 + 2 * p), {3'h0, ue, u});
      host.access(1'b1, 6'(7 + 2 * p), {3'h0, le, l});
      rd(6'(6 + 2 * p), {3'h0, ue, u});
      rd(6'(7 + 2 * p), {3'h0, le, l});
      up[p] = u;
      lo[p] = l;
      en[2 * p] = ue;
      en[2 * p + 1] = le;
      flg = flg & en;
    end
  endtask
  // Model the comparators, then send one result
  task automatic conv(input logic [1:0] ch, input logic [11:0] code);
    int p;
    begin
      p = (ch < 2) ? 0 : ch - 1;
      if (ch >= 2 || ch[0] == (autoScan ? aSel : sSel))
      begin
        flg[2 * p] = en[2 * p] && code >= up[p];
        flg[2 * p + 1] = en[2 * p + 1] && code <= lo[p];
        tup = (ch < 2) ? code >= up[0] : tup;
      end
      flQ.push_back({tup, flg});
      intQ.push_back(route && |flg);
      @(negedge mclk);
      convChannel = ch;
      convCode = code;
      convValid = 1'b1;
      @(negedge mclk);
      convValid = 1'b0;
      convCode = ~code;
      repeat (2) @(negedge mclk);
    end
  endtask
  ////////////////////
  // Result watcher; a phase length is kept when the phase ends
  always @(posedge mclk)
  begin
    rdLate <= regRdEn;
    cvLate <= convValid;
    cvLate2 <= cvLate;
  end
  always @(negedge mclk)
  begin
    preLen = (!prechargeActive && preRun > 0) ? preRun : preLen;
    preRun = prechargeActive ? preRun + 1 : 0;
    senLen = (!senseActive && senRun > 0) ? senRun : senLen;
    senRun = senseActive ? senRun + 1 : 0;
    if (rdLate)
      chk(regRdData, rdQ.pop_front());
    if (cvLate)
      chk({9'h0, tempUpperLimitFlag, limitFlags}, {9'h0, flQ.pop_front()});
    if (cvLate2)
      chk({15'h0, limitInterrupt}, {15'h0, intQ.pop_front()});
  end
  // A hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    final_report();
  end
  ////////////////////
  initial
  begin
    int r;
    logic [1:0] ch;
    logic [2:0] snap;
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    for (int a = 5; a < 12; a++)
      rd(6'(a), (a == 5 || a[0]) ? 16'h0000 : 16'h0fff);
    rd(6'h0c, 16'h0000);
    for (int k = 0; k < 8; k++)
    begin
      penSense = k[0];
      host.access(1'b1, 6'h05, 16'(k * 8 + 7 - k));
      rd(6'h05, 16'(k * 8 + 7 - k));
      repeat (80) @(negedge mclk);
      chk(16'(preLen), 16'(PC[k == 6 ? 7 : k]));
      chk(16'(senLen), 16'(SC[7 - k]));
      chk({15'h0, touchDetected}, {15'h0, k[0]});
    end
    // Frozen clock enable: phases, touch result and a written field all hold
    clkEn = 1'b0;
    snap = {prechargeActive, senseActive, touchDetected};
    host.access(1'b1, 6'h05, 16'h0040);
    repeat (20)
    begin
      @(negedge mclk);
      chk({13'h0, prechargeActive, senseActive, touchDetected}, {13'h0, snap});
    end
    clkEn = 1'b1;
    rd(6'h05, 16'h0038);
    host.access(1'b1, 6'h05, 16'h0040);
    repeat (30) @(negedge mclk);
    chk({13'h0, prechargeActive, senseActive, touchDetected}, 16'h0000);
    for (int i = 0; i < 48; i++)
    begin
      if (i % 6 == 0)
        setlim(i / 6 % 3, 1'($random(seed)), 12'($random(seed)), 1'($random(seed)), 12'($random(seed)));
      r = $random(seed);
      {autoScan, aSel, sSel, route} = r[3:0];
      ch = r[5:4];
      conv(ch, r[7] ? 12'(r >> 12) : (r[6] ? up[ch < 2 ? 0 : ch - 1] : lo[ch < 2 ? 0 : ch - 1]));
    end
    final_report();
  end
endmodule
`default_nettype wire
